// >>> core/dac_ctrl_pkg.sv
// shared constants for the dac toggle, monitor and thermal control block
package dac_ctrl_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ctrl_offset      = 8'h00;
  localparam logic [7:0] command_offset   = 8'h04;
  localparam logic [7:0] monitor_offset   = 8'h08;
  localparam logic [7:0] status_offset    = 8'h0C;
  localparam logic [7:0] irq_status_offset = 8'h10;
  localparam logic [7:0] irq_mask_offset  = 8'h14;
  localparam logic [7:0] dac_read_offset  = 8'h18;
  // command word layout
  localparam int cmd_data_lsb   = 0;
  localparam int cmd_addr_lsb   = 16;
  localparam int cmd_regsel_lsb = 20;
  localparam logic [3:0] ctrl_channel_code = 4'hC;
  localparam logic [1:0] regsel_ctrl       = 2'h0;
  localparam logic [1:0] regsel_a          = 2'h3;
  localparam logic [1:0] regsel_b          = 2'h2;
  // 14-bit variant control bit positions
  localparam int wide_ref_level_bit  = 12;
  localparam int wide_ref_source_bit = 10;
  localparam int wide_thermal_bit    = 8;
  localparam int wide_toggle_lo_bit  = 2;
  // 12-bit variant control bit positions
  localparam int small_ref_level_bit  = 10;
  localparam int small_ref_source_bit = 8;
  localparam int small_thermal_bit    = 6;
  localparam int small_toggle_lo_bit  = 0;
  // monitor selector encodings
  localparam logic [5:0] monitor_off_code = 6'h3F;
  localparam logic [5:0] monitor_in1_code = 6'h3D;
  localparam logic [5:0] monitor_in2_code = 6'h3E;
  // reset values
  localparam logic [15:0] ctrl_reset_value = 16'h0000;
  // status and interrupt bit positions
  localparam int evt_shutdown = 0;
  localparam int evt_load     = 1;
  localparam int evt_discard  = 2;
  localparam int evt_count    = 3;
  // soft power-up command bit in the command register
  localparam int soft_powerup_bit = 24;
endpackage : dac_ctrl_pkg

// >>> core/dac_data_mem.sv
// per-channel A or B data store with registered read
`timescale 1ns/1ps
module dac_data_mem
  import dac_ctrl_pkg::*;
#(
  parameter int width    = 14,
  parameter int channels = 16,
  parameter int aw       = 4
) (
  input  wire logic             clock,
  input  wire logic             we,
  input  wire logic [aw-1:0]    waddr,
  input  wire logic [width-1:0] wdata,
  input  wire logic [aw-1:0]    raddr,
  output logic      [width-1:0] rdata
);
  logic [width-1:0] mem [channels];

  if (channels > (1 << aw)) begin : g_bad_depth
    $error("channels exceed the address width");
  end

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : dac_data_mem

// >>> core/dac_toggle_monitor_thermal_ctrl.sv
// control for reference, monitor mux, toggle mode and thermal shutdown
// Function
// - external reference selected after power-up
// - 14-bit: bit12 level, bit10 internal source
// - 12-bit: bit10 level, bit8 internal source
// - monitor routes addressed channel once enabled
// - monitor address 63 tristates monitor pin
// - two external monitor inputs are selectable
// - regsel 00, address 1100 writes control
// - toggle enabled per group of eight
// - B writes only while group toggles
// - each strobe alternates A and B, A first
// - first strobe after disable loads A
// - thermal monitor enable bit per variant
// - overtemperature powers down all amplifiers
// - recover by soft power-up or disable
// - 12-bit: bit1 channels 8-15, bit0 0-7
// - strobe during busy applied after busy
`timescale 1ns/1ps
module dac_toggle_monitor_thermal_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter bit small_variant = 1'b0,
  parameter int channels      = 16,
  parameter int width         = 14
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        load_strobe_n,
  input  wire logic        busy_n,
  input  wire logic        over_temp,
  output logic             monitor_oe_n,
  output logic [5:0]       monitor_route,
  output logic             amps_powered,
  output logic             internal_ref_on,
  output logic             ref_level_high,
  output logic             irq
);
  localparam int aw = 4;
  localparam int groups = channels / 8;

  // the command word carries 16 data bits and the channel walk needs whole groups of eight
  if (channels != 8 && channels != 16) begin : g_bad_channels
    $error("channels must be 8 or 16");
  end
  if (width < 1 || width > 16) begin : g_bad_width
    $error("width must fit the 16-bit data field");
  end
  if (small_variant && width != 12) begin : g_bad_variant
    $error("small variant is 12-bit");
  end

  function automatic logic [3:0] bit_pos(input int wide, input int narrow);
    bit_pos = small_variant ? 4'(narrow) : 4'(wide);
  endfunction : bit_pos

  logic [15:0] ctrl_q;
  logic [5:0]  monitor_q;
  logic [evt_count-1:0] irq_status_q;
  logic [evt_count-1:0] irq_mask_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        shutdown_q;
  logic [1:0]  toggle_state_q;
  logic [1:0]  was_toggling_q;
  logic        pending_q;
  logic [2:0]  strobe_sync_q;
  logic [2:0]  busy_sync_q;
  logic [2:0]  temp_sync_q;
  logic        strobe_level_q;
  logic        busy_level_q;
  logic        temp_level_q;
  logic [width-1:0] dac_q [channels];
  logic [aw-1:0] load_idx_q;
  logic        loading_q;
  logic        load_side_b_q;
  logic [aw-1:0] read_sel_q;

  // a change counts once second and third flops agree
  // strobe and temperature reset values match the idle pin levels, so no false strobe follows reset; busy resets to its busy level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobe_sync_q  <= 3'h7;
      busy_sync_q    <= 3'h0;
      temp_sync_q    <= 3'h0;
      strobe_level_q <= 1'b1;
      busy_level_q   <= 1'b0;
      temp_level_q   <= 1'b0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[1:0], load_strobe_n};
      busy_sync_q   <= {busy_sync_q[1:0], busy_n};
      temp_sync_q   <= {temp_sync_q[1:0], over_temp};
      if (strobe_sync_q[1] == strobe_sync_q[2]) strobe_level_q <= strobe_sync_q[2];
      if (busy_sync_q[1] == busy_sync_q[2]) busy_level_q <= busy_sync_q[2];
      if (temp_sync_q[1] == temp_sync_q[2]) temp_level_q <= temp_sync_q[2];
    end
  end

  wire strobe_fall = strobe_level_q && (strobe_sync_q[2:1] == 2'b00);

  // bus decode
  // ack is registered and gates the request, so a held stb is taken every second cycle
  wire bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr        = bus_req && wb_we_i;
  wire hit_ctrl  = wb_adr_i == ctrl_offset;
  wire hit_cmd   = wb_adr_i == command_offset;
  wire hit_mon   = wb_adr_i == monitor_offset;
  wire hit_stat  = wb_adr_i == status_offset;
  wire hit_ist   = wb_adr_i == irq_status_offset;
  wire hit_imask = wb_adr_i == irq_mask_offset;
  wire hit_dac   = wb_adr_i == dac_read_offset;
  wire full_word = wb_sel_i == 4'hF;

  wire [1:0]  cmd_regsel = wb_dat_i[cmd_regsel_lsb +: 2];
  wire [3:0]  cmd_addr   = wb_dat_i[cmd_addr_lsb +: 4];
  wire [15:0] cmd_data   = wb_dat_i[cmd_data_lsb +: 16];
  wire        cmd_wr     = wr && hit_cmd && full_word;
  wire        ctrl_write = (cmd_wr && cmd_regsel == regsel_ctrl && cmd_addr == ctrl_channel_code)
                           || (wr && hit_ctrl && full_word);
  wire        soft_powerup = cmd_wr && wb_dat_i[soft_powerup_bit];

  // control field decode per variant
  wire [3:0] tog_lo = bit_pos(wide_toggle_lo_bit, small_toggle_lo_bit);
  wire [1:0] toggle_en = ctrl_q[tog_lo +: 2];
  wire thermal_en = ctrl_q[bit_pos(wide_thermal_bit, small_thermal_bit)];

  // b writes outside toggle mode are dropped and flagged, not stored
  wire [aw-1:0] cmd_chan   = cmd_addr;
  wire          cmd_group  = (channels == 16) ? cmd_chan[3] : 1'b0;
  wire          chan_valid = 5'(cmd_chan) < 5'(channels);
  wire          cmd_data_sel = cmd_wr && chan_valid && !(cmd_regsel == regsel_ctrl);
  wire          a_write = cmd_data_sel && cmd_regsel == regsel_a;
  wire          b_req   = cmd_data_sel && cmd_regsel == regsel_b;
  wire          b_write = b_req && toggle_en[cmd_group];
  wire          b_discard = b_req && !toggle_en[cmd_group];

  // memories; reads walk channels during a load
  logic [width-1:0] a_rdata;
  logic [width-1:0] b_rdata;

  dac_data_mem #(.width(width), .channels(channels), .aw(aw)) a_mem (
    .clock (clock),
    .we    (a_write),
    .waddr (cmd_chan),
    .wdata (cmd_data[width-1:0]),
    .raddr (load_idx_q),
    .rdata (a_rdata)
  );

  dac_data_mem #(.width(width), .channels(channels), .aw(aw)) b_mem (
    .clock (clock),
    .we    (b_write),
    .waddr (cmd_chan),
    .wdata (cmd_data[width-1:0]),
    .raddr (load_idx_q),
    .rdata (b_rdata)
  );

  // strobe handling: remembered while busy, applied once busy ends
  // a strobe during a running walk is queued rather than restarting it
  wire strobe_event = strobe_fall || pending_q;
  wire start_load   = strobe_event && busy_level_q && !loading_q;
  // strobe and control write in one cycle: the strobe advances, then the write may clear
  wire [1:0] toggle_next = start_load ? (toggle_en & ~toggle_state_q) : toggle_state_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_q      <= 1'b0;
      toggle_state_q <= 2'h0;
      was_toggling_q <= 2'h0;
      loading_q      <= 1'b0;
      load_idx_q     <= '0;
      load_side_b_q  <= 1'b0;
    end else begin
      pending_q <= (strobe_fall && (!busy_level_q || loading_q)) || (pending_q && !start_load);
      if (start_load) begin
        loading_q     <= 1'b1;
        load_idx_q    <= '0;
        load_side_b_q <= 1'b0;
        // per group: next side is A first, then alternate; disabled groups use A
        toggle_state_q <= toggle_next;
        was_toggling_q <= toggle_en & toggle_state_q;
      end else if (loading_q) begin
        load_side_b_q <= 1'b1;
        if (load_side_b_q) begin
          load_idx_q <= load_idx_q + 1'b1;
          load_side_b_q <= 1'b0;
          if (5'(load_idx_q) == 5'(channels - 1)) loading_q <= 1'b0;
        end
      end
      if (ctrl_write) begin
        // re-enable starts from A again
        toggle_state_q <= toggle_next & cmd_or_ctrl_toggle();
      end
    end
  end

  function automatic logic [1:0] cmd_or_ctrl_toggle();
    logic [15:0] v;
    v = hit_cmd ? cmd_data : wb_dat_i[15:0];
    cmd_or_ctrl_toggle = v[tog_lo +: 2];
  endfunction : cmd_or_ctrl_toggle

  // dac registers filled on the second cycle of each channel slot
  // the memory read register costs one cycle, hence two cycles a channel
  wire          load_group = (channels == 16) ? load_idx_q[3] : 1'b0;
  wire          use_b      = was_toggling_q[load_group];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < channels; i++) dac_q[i] <= '0;
    end else if (loading_q && load_side_b_q) begin
      dac_q[load_idx_q] <= use_b ? b_rdata : a_rdata;
    end
  end

  // control register, monitor selector, thermal state
  // cooling alone does not clear a trip; the host must power up or disable
  wire new_thermal = hit_cmd ? cmd_data[bit_pos(wide_thermal_bit, small_thermal_bit)]
                             : wb_dat_i[bit_pos(wide_thermal_bit, small_thermal_bit)];
  wire trip = thermal_en && temp_level_q && !shutdown_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= ctrl_reset_value;
      monitor_q  <= monitor_off_code;
      shutdown_q <= 1'b0;
    end else begin
      if (ctrl_write) ctrl_q <= hit_cmd ? cmd_data : wb_dat_i[15:0];
      if (wr && hit_mon && full_word) monitor_q <= wb_dat_i[5:0];
      if (trip) shutdown_q <= 1'b1;
      else if ((soft_powerup && !temp_level_q) || (ctrl_write && !new_thermal)) shutdown_q <= 1'b0;
    end
  end

  // monitor routing: channel, external input, or off
  // the pin stays three-stated until the host sets the monitor enable
  wire mon_enable = ctrl_q[15];
  wire mon_is_chan = 7'(monitor_q) < 7'(channels);
  wire mon_is_ext  = monitor_q == monitor_in1_code || monitor_q == monitor_in2_code;
  wire mon_drive   = mon_enable && (mon_is_chan || mon_is_ext) && monitor_q != monitor_off_code;

  // interrupts: set beats write-one-to-clear
  wire [evt_count-1:0] events = {b_discard, start_load, trip};
  wire [evt_count-1:0] w1c    = (wr && hit_ist) ? wb_dat_i[evt_count-1:0] : '0;
  wire [evt_count-1:0] status_next = (irq_status_q & ~w1c) | events;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= '0;
      irq_mask_q   <= '0;
    end else begin
      irq_status_q <= status_next;
      if (wr && hit_imask) irq_mask_q <= wb_dat_i[evt_count-1:0];
    end
  end

  // read mux
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) read_sel_q <= '0;
    else if (wr && hit_dac) read_sel_q <= wb_dat_i[aw-1:0];
  end
  wire [31:0] status_word = {27'h0, busy_level_q, pending_q, loading_q, toggle_state_q[0], shutdown_q};
  wire [31:0] rd_mux = hit_ctrl  ? {16'h0, ctrl_q} :
                       hit_mon   ? {26'h0, monitor_q} :
                       hit_stat  ? status_word :
                       hit_ist   ? {29'h0, irq_status_q} :
                       hit_imask ? {29'h0, irq_mask_q} :
                       hit_dac   ? 32'(dac_q[read_sel_q]) : 32'h0000_0000;

  // outputs from flops; ack one cycle after request, unmapped reads zero
  // amplifiers are held off in reset and come up one edge after release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q           <= 1'b0;
      dat_q           <= 32'h0000_0000;
      monitor_oe_n    <= 1'b1;
      monitor_route   <= monitor_off_code;
      amps_powered    <= 1'b0;
      internal_ref_on <= 1'b0;
      ref_level_high  <= 1'b0;
      irq             <= 1'b0;
    end else begin
      ack_q           <= bus_req;
      dat_q           <= rd_mux;
      monitor_oe_n    <= !mon_drive;
      monitor_route   <= mon_drive ? monitor_q : monitor_off_code;
      amps_powered    <= !(shutdown_q || trip);
      internal_ref_on <= ctrl_q[bit_pos(wide_ref_source_bit, small_ref_source_bit)];
      ref_level_high  <= ctrl_q[bit_pos(wide_ref_level_bit, small_ref_level_bit)];
      irq             <= |(status_next & irq_mask_q);
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
endmodule : dac_toggle_monitor_thermal_ctrl

// >>> testbench/dac_ctrl_props.sv
// port-level assertions for the dac control block
`timescale 1ns/1ps
module dac_ctrl_props
  import dac_ctrl_pkg::*;
#(
  parameter bit small_variant = 1'b0
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        over_temp,
  input wire logic        monitor_oe_n,
  input wire logic [5:0]  monitor_route,
  input wire logic        amps_powered,
  input wire logic        internal_ref_on,
  input wire logic        ref_level_high,
  input wire logic        irq
);
  logic       req;
  logic       wr_ctrl;
  logic [2:0] exp_d;
  logic [2:0] exp_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = req && wb_we_i && wb_sel_i == 4'hF && (wb_adr_i == ctrl_offset ||
    (wb_adr_i == command_offset && wb_dat_i[21:20] == regsel_ctrl && wb_dat_i[19:16] == ctrl_channel_code));
  // {thermal, level, source}; the variant moves all three bits
  assign exp_d = small_variant ? {wb_dat_i[6], wb_dat_i[10], wb_dat_i[8]} : {wb_dat_i[8], wb_dat_i[12], wb_dat_i[10]};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exp_q <= 3'h0;
    end else if (wr_ctrl) begin
      exp_q <= exp_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  // the cycle after a control write is left out: the register may still be landing
  a_ref_track: assert property (!wr_ctrl && !$past(wr_ctrl) |->
    internal_ref_on == exp_q[0] && ref_level_high == exp_q[1]) else $error("reference bits differ from control");
  a_mon_tristate: assert property (monitor_route == monitor_off_code |-> monitor_oe_n)
    else $error("monitor driven while off code selected");
  a_thermal_trip: assert property ((exp_q[2] && over_temp) [*8] |-> !amps_powered)
    else $error("amplifiers still on when hot");
  a_trip_cause: assert property ($fell(amps_powered) |-> exp_q[2])
    else $error("shutdown without thermal monitor enabled");
  a_thermal_recover: assert property ($fell(exp_q[2]) |-> ##[1:6] amps_powered)
    else $error("amplifiers not back after monitor disabled");
  cover property (wr_ctrl);
  cover property ($fell(amps_powered));
  cover property (irq);
endmodule : dac_ctrl_props

bind dac_toggle_monitor_thermal_ctrl dac_ctrl_props #(.small_variant(small_variant)) u_dac_ctrl_props (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .over_temp(over_temp),
  .monitor_oe_n(monitor_oe_n), .monitor_route(monitor_route), .amps_powered(amps_powered),
  .internal_ref_on(internal_ref_on), .ref_level_high(ref_level_high), .irq(irq));

// >>> testbench/dac_host_model.sv
// host side: classic wishbone master issuing single register cycles
`timescale 1ns/1ps
module dac_host_model (
  input  wire logic        clock,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  initial begin
    {cyc, stb, we, adr, sel, dat_w} = '0;
  end
  // request held until ack is sampled high at a rising edge; data taken and request released there
  // idle data is scrambled so a stale word is never mistaken for a fresh one
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
    do @(posedge clock); while (ack !== 1'b1);
    q = dat_r;
    {cyc, stb, we, dat_w} <= {3'b000, ~d};
  endtask : access
endmodule : dac_host_model

// >>> testbench/dac_toggle_monitor_thermal_ctrl_bench.sv
// self-checking bench for the dac control block
`timescale 1ns/1ps
module dac_toggle_monitor_thermal_ctrl_bench;
  import dac_ctrl_pkg::*;
  logic        clock, rst_n, cyc, stb, we, ack, load_strobe_n, busy_n, over_temp;
  logic        monitor_oe_n, amps_powered, internal_ref_on, ref_level_high, irq;
  logic        narrow_ref_on, narrow_ref_level, narrow_irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [5:0]  monitor_route;
  logic [5:0]  codes [4];
  logic [31:0] dat_w, dat_r, rd;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  dac_host_model u_dac_host_model (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack));
  dac_toggle_monitor_thermal_ctrl u_dac_toggle_monitor_thermal_ctrl (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .load_strobe_n(load_strobe_n), .busy_n(busy_n), .over_temp(over_temp),
    .monitor_oe_n(monitor_oe_n), .monitor_route(monitor_route), .amps_powered(amps_powered),
    .internal_ref_on(internal_ref_on), .ref_level_high(ref_level_high), .irq(irq));
  // 12-bit layout on the same bus; only its reference and interrupt outputs are judged
  dac_toggle_monitor_thermal_ctrl #(.small_variant(1'b1), .width(12)) u_dac_toggle_monitor_thermal_ctrl_narrow (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(), .wb_ack_o(), .load_strobe_n(load_strobe_n), .busy_n(busy_n),
    .over_temp(over_temp), .monitor_oe_n(), .monitor_route(), .amps_powered(), .internal_ref_on(narrow_ref_on),
    .ref_level_high(narrow_ref_level), .irq(narrow_irq));
  always #2 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_dac_host_model.access(w, a, d, rd);
    repeat (2) @(negedge clock);
  endtask : wr
  task automatic cmd(input logic [1:0] rs, input logic [3:0] ch, input logic [15:0] d);
    wr(1'b1, command_offset, {10'h000, rs, ch, d});
  endtask : cmd
  // pulse outlasts the input synchroniser; n cycles leave room for the channel walk
  task automatic strobe(input int n);
    @(posedge clock);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge clock);
    load_strobe_n <= 1'b1;
    repeat (n) @(negedge clock);
  endtask : strobe
  task automatic dac_is(input logic [3:0] ch, input logic [31:0] exp);
    wr(1'b1, dac_read_offset, {28'h0000000, ch});
    wr(1'b0, dac_read_offset, 32'h0);
    chk("dac", exp, rd);
  endtask : dac_is
  task automatic heat(input logic v);
    @(posedge clock);
    over_temp <= v;
    repeat (12) @(negedge clock);
  endtask : heat
  task automatic t_reset;
    chk("ref_on", 32'h0, 32'(internal_ref_on));
    chk("mon_oe_n", 32'h1, 32'(monitor_oe_n));
    wr(1'b0, ctrl_offset, 32'h0);
    chk("ctrl", 32'(ctrl_reset_value), rd);
    wr(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset
  task automatic t_reference;
    cmd(regsel_ctrl, ctrl_channel_code, 16'h1400);
    chk("ref_on", 32'h1, 32'(internal_ref_on));
    chk("ref_level", 32'h1, 32'(ref_level_high));
    wr(1'b0, ctrl_offset, 32'h0);
    chk("ctrl", 32'h0000_1400, rd);
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0400);
    chk("ref_level", 32'h0, 32'(ref_level_high));
    $display("test reference done");
  endtask : t_reference
  task automatic t_monitor;
    codes = '{6'h05, 6'h0F, monitor_in1_code, monitor_in2_code};
    cmd(regsel_ctrl, ctrl_channel_code, 16'h8000);
    foreach (codes[i]) begin
      wr(1'b1, monitor_offset, {26'h0, codes[i]});
      chk("route", 32'(codes[i]), 32'(monitor_route));
      chk("mon_oe_n", 32'h0, 32'(monitor_oe_n));
    end
    wr(1'b1, monitor_offset, {26'h0, monitor_off_code});
    chk("mon_oe_n", 32'h1, 32'(monitor_oe_n));
    $display("test monitor done");
  endtask : t_monitor
  task automatic t_toggle;
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0004);
    cmd(regsel_a, 4'h0, 16'h0111);
    cmd(regsel_a, 4'h1, 16'h0000);
    cmd(regsel_b, 4'h0, 16'h0222);
    cmd(regsel_b, 4'h8, 16'h0333);
    wr(1'b0, irq_status_offset, 32'h0);
    chk("discard", 32'h4, rd & 32'h4);
    for (int i = 0; i < 4; i++) begin
      strobe(60);
      dac_is(4'h0, i[0] ? 32'h0222 : 32'h0111);
    end
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0000);
    strobe(60);
    dac_is(4'h0, 32'h0111);
    cmd(regsel_a, 4'h1, 16'h0055);
    @(posedge clock);
    busy_n <= 1'b0;
    strobe(20);
    dac_is(4'h1, 32'h0000);
    @(posedge clock);
    busy_n <= 1'b1;
    repeat (60) @(negedge clock);
    dac_is(4'h1, 32'h0055);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_thermal;
    wr(1'b1, irq_status_offset, 32'h7);
    wr(1'b1, irq_mask_offset, 32'h1);
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0100);
    heat(1'b1);
    chk("amps", 32'h0, 32'(amps_powered));
    chk("irq", 32'h1, 32'(irq));
    heat(1'b0);
    wr(1'b1, command_offset, 32'h0100_0000);
    chk("amps", 32'h1, 32'(amps_powered));
    wr(1'b1, irq_status_offset, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    heat(1'b1);
    wr(1'b1, irq_mask_offset, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0400);
    chk("amps", 32'h1, 32'(amps_powered));
    heat(1'b0);
    $display("test thermal done");
  endtask : t_thermal
  // group one enabled on the 12-bit layout: channel 8 takes b data, channel 0 does not
  task automatic t_small;
    wr(1'b1, irq_status_offset, 32'h7);
    wr(1'b1, irq_mask_offset, 32'h4);
    cmd(regsel_ctrl, ctrl_channel_code, 16'h0502);
    chk("narrow_ref_on", 32'h1, 32'(narrow_ref_on));
    chk("narrow_ref_level", 32'h1, 32'(narrow_ref_level));
    cmd(regsel_b, 4'h8, 16'h0123);
    chk("narrow_irq", 32'h0, 32'(narrow_irq));
    cmd(regsel_b, 4'h0, 16'h0123);
    chk("narrow_irq", 32'h1, 32'(narrow_irq));
    $display("test narrow variant done");
  endtask : t_small
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // the tests need under a thousand cycles; far beyond that is a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    clock = 1'b0;
    {rst_n, load_strobe_n, busy_n, over_temp} = 4'b0110;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(negedge clock);
    t_reset();
    t_reference();
    t_monitor();
    t_toggle();
    t_thermal();
    t_small();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(negedge clock);
    t_reset();
    tally_and_finish();
  end
endmodule : dac_toggle_monitor_thermal_ctrl_bench
